// ===== src/cls_tx.sv
// cls_tx: transmit side of a two-wire current-loop sensor link
// assumes comparator and regulator-monitor levels arrive asynchronously from analogue pins
`timescale 1ns/100ps
module cls_tx #(
  parameter int unsigned FRAME_PERIOD = cls_pkg::FRAME_PERIOD_CYC,
  parameter int unsigned TICK_PERIOD  = cls_pkg::SYNC_TICK_CYC,
  parameter int unsigned HALF_BIT     = cls_pkg::HALF_BIT_CYC,
  parameter int unsigned FIFO_DEPTH   = 16
) (
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  input  wire logic                        ce_i,
  input  wire cls_pkg::cls_cfg_t           cfg_i,
  input  wire logic                        above_upper_i,
  input  wire logic                        below_lower_i,
  input  wire logic                        regulator_low_i,
  input  wire logic                        fault_i,
  output logic                             conv_start_o,
  input  wire logic                        conv_done_i,
  input  wire logic [cls_pkg::DATA_W-1:0]  conv_data_i,
  output logic                             conv_ready_o,
  output cls_pkg::cls_cur_t                current_o,
  output logic [2:0]                       phase_o,
  output logic                             frame_active_o
);
  localparam int unsigned PW = cls_pkg::PAY_W;

  // two-stage synchronisers on analogue levels
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  wire        up_s  = sync2_reg[0];
  wire        dn_s  = sync2_reg[1];
  wire        low_s = sync2_reg[2];
  wire        rst   = srst_i || low_s;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else if (ce_i) begin
      sync1_reg <= {regulator_low_i, below_lower_i, above_upper_i};
      sync2_reg <= sync1_reg;
    end
  end

  // fault latch
  logic fault_reg;
  always_ff @(posedge clk_i) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (ce_i && fault_i) begin
      fault_reg <= 1'b1;
    end
  end

  // sync integrator
  logic [15:0] tick_cnt_reg;
  logic [3:0]  integ_reg;
  logic        blank_reg;
  logic        sync_valid;
  wire         tick = (tick_cnt_reg == 16'(TICK_PERIOD - 1));
  wire         sync_on = cfg_i.sync_mode_enable;
  wire         reached = (integ_reg == cls_pkg::SYNC_VALID_CNT);
  wire         tx_done;

  assign sync_valid = ce_i && tick && sync_on && !blank_reg && reached;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
      integ_reg    <= 4'h0;
      blank_reg    <= 1'b0;
    end else if (ce_i) begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (sync_valid) begin
        blank_reg <= 1'b1;
        integ_reg <= 4'h0;
      end else if (blank_reg) begin
        if (tx_done) begin
          blank_reg <= 1'b0;
        end
      end else if (tick && sync_on && !reached) begin
        // residual count drops by one per tick while below the lower level
        if (up_s) begin
          integ_reg <= integ_reg + 4'h1;
        end else if (dn_s && integ_reg != 4'h0) begin
          integ_reg <= integ_reg - 4'h1;
        end
      end
    end
  end

  // self-timed period
  logic [31:0] period_reg;
  wire         period_hit = !sync_on && (period_reg == 32'(FRAME_PERIOD - 1));
  always_ff @(posedge clk_i) begin
    if (rst || sync_on) begin
      period_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      period_reg <= period_hit ? 32'h0000_0000 : period_reg + 32'h0000_0001;
    end
  end

  // one conversion per opportunity; the frame sent now carries the previous result
  wire opportunity = (sync_on ? sync_valid : (ce_i && period_hit));
  logic [PW-1:0] held_reg;
  logic          have_data_reg;
  logic          pend_reg;
  wire [PW-1:0]  fifo_data;
  wire           fifo_valid;
  wire           fifo_in_ready;
  wire           fifo_take = fifo_valid && !pend_reg;

  assign conv_start_o = opportunity;
  assign conv_ready_o = fifo_in_ready;

  cls_fifo #(
    .WIDTH (PW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (rst),
    .ce_i        (ce_i),
    .in_data_i   ({{(PW-cls_pkg::DATA_W){1'b0}}, conv_data_i}),
    .in_valid_i  (conv_done_i),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take)
  );

  // hold latest result; a frame uses the held value captured before this opportunity
  logic [2:0] phase_reg;
  wire        phase5 = (phase_reg == cls_pkg::LAST_PHASE);
  wire        fire = opportunity && (have_data_reg || !phase5);
  logic [PW-1:0] frame_word;
  assign frame_word = fault_reg ? cls_pkg::ERR_FRAME : held_reg;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      held_reg      <= 16'h0000;
      have_data_reg <= 1'b0;
      pend_reg      <= 1'b0;
      phase_reg     <= 3'h0;
    end else if (ce_i) begin
      if (fifo_take) begin
        held_reg      <= fifo_data;
        have_data_reg <= 1'b1;
      end
      pend_reg <= 1'b0;
      if (fire && !phase5) begin
        phase_reg <= phase_reg + 3'h1;
      end
    end
  end

  // manchester serialiser
  cls_pkg::cls_tx_state_t st_reg;
  cls_pkg::cls_tx_state_t st_next;
  logic [PW-1:0] shift_reg;
  // payload frozen at the opportunity, so a result taken during the frame waits a period
  logic [PW-1:0] payload_reg;
  logic [4:0]    bit_cnt_reg;
  logic [15:0]   half_cnt_reg;
  logic          half_reg;
  logic          mod_reg;
  logic          sink_reg;
  wire           half_end = (half_cnt_reg == 16'(HALF_BIT - 1));
  wire           bit_end  = half_end && half_reg;
  wire [1:0]     starts   = cfg_i.manchester_phase_select ? 2'b00 : 2'b10;
  wire           cur_bit  = shift_reg[PW-1];
  // first half level; second half is its inverse
  wire           first_lvl = cur_bit ^ ~cfg_i.manchester_phase_select;
  wire           lvl = half_reg ? ~first_lvl : first_lvl;
  wire           discharge = cfg_i.bus_discharge_enable && sync_on;

  assign tx_done = bit_end && (st_reg == cls_pkg::CLS_STOP);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      cls_pkg::CLS_IDLE: begin
        if (fire) begin
          st_next = cls_pkg::CLS_START;
        end
      end
      cls_pkg::CLS_START: begin
        if (bit_end && bit_cnt_reg == 5'h01) begin
          st_next = cls_pkg::CLS_DATA;
        end
      end
      cls_pkg::CLS_DATA: begin
        if (bit_end && bit_cnt_reg == 5'(PW - 1)) begin
          st_next = cls_pkg::CLS_STOP;
        end
      end
      cls_pkg::CLS_STOP: begin
        if (bit_end) begin
          st_next = cls_pkg::CLS_IDLE;
        end
      end
      default: begin
        st_next = cls_pkg::CLS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      st_reg       <= cls_pkg::CLS_IDLE;
      shift_reg    <= 16'h0000;
      payload_reg  <= 16'h0000;
      bit_cnt_reg  <= 5'h00;
      half_cnt_reg <= 16'h0000;
      half_reg     <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      if (st_reg == cls_pkg::CLS_IDLE) begin
        half_cnt_reg <= 16'h0000;
        half_reg     <= 1'b0;
        bit_cnt_reg  <= 5'h00;
        if (fire) begin
          shift_reg   <= {starts, 14'h0000};
          payload_reg <= frame_word;
        end
      end else begin
        half_cnt_reg <= half_end ? 16'h0000 : half_cnt_reg + 16'h0001;
        if (half_end) begin
          half_reg <= ~half_reg;
        end
        if (bit_end) begin
          if (st_reg == cls_pkg::CLS_START && bit_cnt_reg == 5'h01) begin
            shift_reg   <= payload_reg;
            bit_cnt_reg <= 5'h00;
          end else begin
            shift_reg   <= {shift_reg[PW-2:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
      end
    end
  end

  // current outputs from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst) begin
      mod_reg  <= 1'b0;
      sink_reg <= 1'b0;
    end else if (ce_i) begin
      mod_reg <= (st_reg == cls_pkg::CLS_START || st_reg == cls_pkg::CLS_DATA) && lvl;
      if (sync_valid && discharge) begin
        sink_reg <= 1'b1;
      end else if (fire || !discharge) begin
        sink_reg <= 1'b0;
      end
    end
  end

  assign current_o.modulation_current_step = mod_reg;
  assign current_o.discharge_sink_current  = sink_reg;
  assign phase_o        = phase_reg;
  assign frame_active_o = (st_reg != cls_pkg::CLS_IDLE);
endmodule

// ===== src/cls_pkg.sv
// cls_pkg: constants, states and carrier types of the current-loop sensor link transmitter
// assumes a 200 MHz core clock
package cls_pkg;

  localparam int unsigned CLK_MHZ        = 200;
  // self-timed frame period in us, and the sync integrator tick in us
  localparam int unsigned FRAME_PERIOD_US = 228;
  localparam int unsigned SYNC_TICK_US    = 1;
  localparam int unsigned FRAME_PERIOD_CYC = FRAME_PERIOD_US * CLK_MHZ;
  localparam int unsigned SYNC_TICK_CYC    = SYNC_TICK_US * CLK_MHZ;
  // manchester half-bit length in cycles (bit time 8 us)
  localparam int unsigned HALF_BIT_CYC     = 800;
  localparam logic [3:0]  SYNC_VALID_CNT   = 4'h7;
  localparam int unsigned DATA_W           = 10;
  localparam int unsigned PAY_W            = 16;
  localparam logic [4:0]  START_BITS       = 5'h02;
  localparam logic [2:0]  LAST_PHASE       = 3'h4;
  localparam logic [15:0] ERR_FRAME        = 16'hFC00;

  typedef enum logic [3:0] {
    CLS_IDLE  = 4'b0001,
    CLS_START = 4'b0010,
    CLS_DATA  = 4'b0100,
    CLS_STOP  = 4'b1000
  } cls_tx_state_t;

  typedef struct packed {
    logic manchester_phase_select;
    logic sync_mode_enable;
    logic bus_discharge_enable;
  } cls_cfg_t;

  typedef struct packed {
    logic modulation_current_step;
    logic discharge_sink_current;
  } cls_cur_t;

endpackage

// ===== src/cls_fifo.sv
// cls_fifo: synchronous valid/ready fifo for conversion results
// assumes one clock, synchronous reset and a clock enable shared with its user
`timescale 1ns/100ps
module cls_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] out_reg;
  logic             out_valid_reg;
  wire              push = ce_i && in_valid_i && in_ready_o;
  wire              load = ce_i && (count_reg != '0) && (!out_valid_reg || out_ready_i);
  wire              pop_out = ce_i && out_valid_reg && out_ready_i;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_data_o  = out_reg;
  assign out_valid_o = out_valid_reg;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // output word stands in a register; count holds words still in memory
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
      end
      if (load) begin
        out_reg       <= mem_reg[rd_ptr_reg];
        out_valid_reg <= 1'b1;
        rd_ptr_reg    <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
      end else if (pop_out) begin
        out_valid_reg <= 1'b0;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule

// ===== tb/cls_tx_assertions.sv
// cls_tx_assertions: port-level checks of the current-loop transmitter
// assumes the bench's short counts: frame period 300, half bit 4
`timescale 1ns/100ps
module cls_tx_assertions #(
  parameter int unsigned FRAME_PERIOD = 300,
  parameter int unsigned HALF_BIT     = 4
) (
  input wire logic              clk_i,
  input wire logic              srst_i,
  input wire cls_pkg::cls_cfg_t cfg_i,
  input wire logic              conv_start_o,
  input wire cls_pkg::cls_cur_t current_o,
  input wire logic [2:0]        phase_o,
  input wire logic              frame_active_o
);
  localparam int FP = FRAME_PERIOD;
  localparam int HB = HALF_BIT;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_reset_clear: assert property (disable iff (1'h0)
    srst_i |=> current_o == '0 && phase_o == 3'h0 && !frame_active_o) else $error("reset kept");
  a_idle_quiet: assert property (
    !frame_active_o |-> !current_o.modulation_current_step) else $error("idle modulation");
  a_start_bits: assert property (
    $rose(frame_active_o) |-> ##2 !current_o.modulation_current_step ##HB
    current_o.modulation_current_step ##HB
    (current_o.modulation_current_step != cfg_i.manchester_phase_select)) else $error("start bits");
  a_one_start: assert property (
    conv_start_o |=> !conv_start_o) else $error("start pulse too long");
  a_frame_follows: assert property (
    conv_start_o && phase_o != 3'h4 |=> frame_active_o) else $error("no frame");
  a_blank_frame: assert property (
    frame_active_o |-> !conv_start_o) else $error("start during frame");
  a_sink_on: assert property (
    conv_start_o && cfg_i.sync_mode_enable && cfg_i.bus_discharge_enable
    |=> current_o.discharge_sink_current) else $error("no sink");
  a_sink_gated: assert property (
    !(cfg_i.sync_mode_enable && cfg_i.bus_discharge_enable)
    |=> !current_o.discharge_sink_current) else $error("sink while disabled");
  a_async_period: assert property (
    conv_start_o && !cfg_i.sync_mode_enable
    |-> ##FP (conv_start_o || cfg_i.sync_mode_enable)) else $error("period");
endmodule

bind cls_tx cls_tx_assertions #(.FRAME_PERIOD(FRAME_PERIOD), .HALF_BIT(HALF_BIT))
  i_cls_tx_assertions (.clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg_i),
  .conv_start_o(conv_start_o), .current_o(current_o), .phase_o(phase_o),
  .frame_active_o(frame_active_o));

// ===== tb/cls_partner.sv
// cls_partner: control module making sync pulses, plus the converter
// assumes the bench calls sync_pulse at a falling edge
`timescale 1ns/100ps
module cls_partner #(
  parameter int unsigned TICK = 4
) (
  input  wire logic       clk_i,
  input  wire logic       conv_start_i,
  output logic            above_upper_o,
  output logic            below_lower_o,
  output logic            conv_done_o,
  output logic      [9:0] conv_data_o
);
  int unsigned conv_delay = 3;
  logic [9:0]  last_data  = 10'h000;
  initial begin
    above_upper_o = 1'h0;
    below_lower_o = 1'h1;
    conv_done_o   = 1'h0;
    conv_data_o   = 10'h200;
  end
  task automatic sync_pulse(input int up, input int down);
    above_upper_o = 1'h1;
    below_lower_o = 1'h0;
    repeat (up * TICK) @(negedge clk_i);
    above_upper_o = 1'h0;
    below_lower_o = 1'h1;
    repeat (down * TICK) @(negedge clk_i);
  endtask
  // converter answers each start after conv_delay cycles
  always @(posedge clk_i) begin
    if (conv_start_i) begin
      repeat (conv_delay) @(negedge clk_i);
      conv_data_o = conv_data_o + 10'h001;
      last_data   = conv_data_o;
      conv_done_o = 1'h1;
      @(negedge clk_i);
      conv_done_o = 1'h0;
    end
  end
endmodule

// ===== tb/cls_tx_tb.sv
// cls_tx_tb: self-checking bench of the current-loop transmitter
// assumes short counts: frame period 300, tick 4, half bit 4
`timescale 1ns/100ps
module cls_tx_tb;
  localparam int unsigned HB = 4;
  logic              clk_i = 1'h0;
  logic              srst_i = 1'h1;
  logic              ce_i = 1'h1;
  cls_pkg::cls_cfg_t cfg_i = '0;
  logic              regulator_low_i = 1'h0;
  logic              fault_i = 1'h0;
  logic              above_upper_i;
  logic              below_lower_i;
  logic              conv_start_o;
  logic              conv_done_i;
  logic        [9:0] conv_data_i;
  cls_pkg::cls_cur_t current_o;
  logic        [2:0] phase_o;
  logic              frame_active_o;
  logic       [17:0] fr;
  logic        [9:0] exp_d;
  int                n_fail = 0;
  int                compares = 0;
  int                cycles = 0;

  cls_tx #(.FRAME_PERIOD(300), .TICK_PERIOD(4), .HALF_BIT(HB), .FIFO_DEPTH(16)) i_cls_tx (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .cfg_i(cfg_i),
    .above_upper_i(above_upper_i), .below_lower_i(below_lower_i),
    .regulator_low_i(regulator_low_i), .fault_i(fault_i), .conv_start_o(conv_start_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .conv_ready_o(),
    .current_o(current_o), .phase_o(phase_o), .frame_active_o(frame_active_o));
  cls_partner #(.TICK(4)) i_cls_partner (
    .clk_i(clk_i), .conv_start_i(conv_start_o), .above_upper_o(above_upper_i),
    .below_lower_o(below_lower_i), .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));

  initial forever #2.5 clk_i = ~clk_i;

  task automatic conclude();
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [2:0] c);
    srst_i = 1'h1;
    fault_i = 1'h0;
    cfg_i = c;
    repeat (16) @(negedge clk_i);
    srst_i = 1'h0;
  endtask

  // waits for a frame and decodes its 18 coded bits into fr
  task automatic get_frame();
    int   i;
    logic h;
    i = 0;
    while (frame_active_o !== 1'h1 && i < 400) begin
      @(negedge clk_i);
      i++;
    end
    chk(frame_active_o, 1'h1);
    exp_d = i_cls_partner.last_data;
    repeat (2) @(negedge clk_i);
    for (i = 0; i < 18; i++) begin
      h = current_o.modulation_current_step;
      fr[17-i] = h ^ !cfg_i.manchester_phase_select;
      repeat (HB) @(negedge clk_i);
      chk(current_o.modulation_current_step, !h);
      repeat (HB) @(negedge clk_i);
    end
    chk(current_o.modulation_current_step, 1'h0);
    repeat (2 * HB + 2) @(negedge clk_i);
    chk(frame_active_o, 1'h0);
  endtask

  // single self-timed device on the bus
  task automatic t_async();
    int k;
    do_reset(3'h0);
    for (k = 0; k < 6; k++) begin
      get_frame();
      chk(fr[17:16], 2'h2);
      if (k > 3) chk(fr[15:0], {6'h00, exp_d});
    end
    chk(phase_o, 3'h4);
  endtask

  task automatic t_fault();
    do_reset(3'h0);
    fault_i = 1'h1;
    repeat (2) begin
      get_frame();
      chk(fr[15:0], cls_pkg::ERR_FRAME);
    end
  endtask

  task automatic t_sync();
    int k;
    do_reset(3'h7);
    i_cls_partner.conv_delay = 100;
    repeat (400) @(negedge clk_i);
    chk(frame_active_o, 1'h0);
    for (k = 0; k < 6; k++) begin
      fork
        i_cls_partner.sync_pulse(10, 60);
        get_frame();
      join
      chk(fr[17:16], 2'h0);
      if (k > 3) chk(fr[15:0], {6'h00, exp_d});
    end
    chk(phase_o, 3'h4);
    i_cls_partner.conv_delay = 3;
  endtask

  task automatic t_short();
    do_reset(3'h2);
    i_cls_partner.sync_pulse(5, 2);
    fork
      i_cls_partner.sync_pulse(5, 40);
      get_frame();
    join
    i_cls_partner.sync_pulse(5, 40);
    fork
      i_cls_partner.sync_pulse(9, 40);
      get_frame();
    join
  endtask

  task automatic t_reglow();
    do_reset(3'h2);
    fork
      i_cls_partner.sync_pulse(10, 40);
      get_frame();
    join
    chk(phase_o, 3'h1);
    regulator_low_i = 1'h1;
    repeat (4) @(negedge clk_i);
    regulator_low_i = 1'h0;
    repeat (4) @(negedge clk_i);
    chk(phase_o, 3'h0);
  endtask

  initial begin
    t_async();
    t_fault();
    t_sync();
    t_short();
    t_reglow();
    conclude();
  end
endmodule
